// *** logic/adcc_top.sv ***
/*
 Converter control: APB registers, start/done sequencing, timing in
 CPU machine cycles or RC ticks, power-mode abort and wake-up.
 Assumes pclk is the CPU clock, rc_tick is a one-cycle pulse per RC
 oscillator clock synchronous to pclk, and the analog core presents
 the code of the selected channel on analog_code at conversion end.
*/
`timescale 1ns/1ps

`include "adcc_defines.svh"

module adcc_top
   import adcc_pkg::*;
#(
   parameter int CLKS_PER_MC = 1,
   parameter int CONV_MC = 31,
   parameter int SYNC_MC = 3,
   parameter int RC_TICKS = 108
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_idle,
   input wire logic cpu_power_down,
   input wire logic rc_tick,
   input wire logic [7:0] analog_code,
   output logic [1:0] analog_channel,
   output logic analog_enable,
   output logic converting,
   output logic adc_irq,
   output logic cpu_wake
);

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   adcc_ctrl_s ctrl_reg;
   adcc_conv_e conv_reg;
   adcc_bus_e bus_reg;
   logic conversion_done_flag_reg;
   logic [7:0] conversion_result_reg;
   logic result_valid_reg;
   logic aborted_reg;
   logic [1:0] conv_chan_reg;
   logic [7:0] cnt_reg;
   logic [7:0] mc_div_reg;
   logic mc_tick;
   logic bus_write;
   logic ctrl_wr;
   logic start_req;
   logic finish;
   logic abort;
   logic [7:0] hist_data;
   logic [31:0] rd_mux;
   logic rd_err;

   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic is_hist(input logic [11:0] a);
      return (a & `ADCC_HIST_MASK) == `ADCC_OFS_HIST;
   endfunction

   function automatic logic is_mapped(input logic [11:0] a);
      return a == `ADCC_OFS_CTRL || a == `ADCC_OFS_RESULT ||
             a == `ADCC_OFS_STATUS || is_hist(a);
   endfunction

   // -------------------------------------------------------------
   // APB slave: one wait state, answer registered
   // -------------------------------------------------------------
   // The wait state lets the history memory register its read data
   // before prdata is loaded, so every output stays a flop.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_reg <= ADCC_BUS_IDLE;
      end else if (clk_en) begin
         case (bus_reg)
            ADCC_BUS_IDLE: begin
               if (psel && !penable) begin
                  bus_reg <= ADCC_BUS_WAIT;
               end
            end
            ADCC_BUS_WAIT: begin
               bus_reg <= ADCC_BUS_ANSWER;
            end
            ADCC_BUS_ANSWER: begin
               bus_reg <= ADCC_BUS_IDLE;
            end
            default: begin
               bus_reg <= ADCC_BUS_IDLE;
            end
         endcase
      end
   end

   always_comb begin
      rd_err = !is_mapped(paddr);
      rd_mux = 32'h0000_0000;
      if (paddr == `ADCC_OFS_CTRL) begin
         rd_mux[`ADCC_CTRL_CHAN_LSB +: 2] = ctrl_reg.channel_select_field;
         rd_mux[`ADCC_CTRL_RCSEL] = ctrl_reg.rc_clock_select;
         rd_mux[`ADCC_CTRL_START] = conv_reg != ADCC_IDLE;
         rd_mux[`ADCC_CTRL_DONE] = conversion_done_flag_reg;
         rd_mux[`ADCC_CTRL_ENABLE] = ctrl_reg.enable;
         rd_mux[`ADCC_CTRL_IRQEN] = ctrl_reg.irq_en;
      end else if (paddr == `ADCC_OFS_RESULT) begin
         rd_mux[7:0] = conversion_result_reg;
      end else if (paddr == `ADCC_OFS_STATUS) begin
         rd_mux[`ADCC_STAT_VALID] = result_valid_reg;
         rd_mux[`ADCC_STAT_ABORT] = aborted_reg;
         rd_mux[`ADCC_STAT_BUSY] = conv_reg != ADCC_IDLE;
      end else if (is_hist(paddr)) begin
         rd_mux[7:0] = hist_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (clk_en) begin
         pready <= bus_reg == ADCC_BUS_WAIT;
         pslverr <= bus_reg == ADCC_BUS_WAIT && rd_err;
         if (bus_reg == ADCC_BUS_WAIT && !pwrite) begin
            prdata <= rd_mux;
         end
      end
   end

   assign bus_write = bus_reg == ADCC_BUS_ANSWER && psel && penable &&
                      pwrite && pready;
   assign ctrl_wr = bus_write && paddr == `ADCC_OFS_CTRL;

   // -------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------
   // Channel and clock source are frozen while busy or done, so a
   // running conversion cannot change under software.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg.channel_select_field <= `ADCC_RST_CHAN;
         ctrl_reg.rc_clock_select <= 1'b0;
         ctrl_reg.enable <= 1'b0;
         ctrl_reg.irq_en <= 1'b0;
      end else if (clk_en && ctrl_wr) begin
         ctrl_reg.enable <= pwdata[`ADCC_CTRL_ENABLE];
         ctrl_reg.irq_en <= pwdata[`ADCC_CTRL_IRQEN];
         if (conv_reg == ADCC_IDLE && !conversion_done_flag_reg) begin
            ctrl_reg.channel_select_field <=
               pwdata[`ADCC_CTRL_CHAN_LSB +: 2];
            ctrl_reg.rc_clock_select <= pwdata[`ADCC_CTRL_RCSEL];
         end
      end
   end

   // Start is blocked while busy or while the done flag is still set
   assign start_req = ctrl_wr && pwdata[`ADCC_CTRL_START] &&
                      conv_reg == ADCC_IDLE &&
                      !conversion_done_flag_reg;

   // -------------------------------------------------------------
   // Machine cycle divider
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mc_div_reg <= 8'h00;
      end else if (clk_en) begin
         if (mc_div_reg == 8'(CLKS_PER_MC - 1)) begin
            mc_div_reg <= 8'h00;
         end else begin
            mc_div_reg <= mc_div_reg + 8'h01;
         end
      end
   end

   assign mc_tick = mc_div_reg == 8'(CLKS_PER_MC - 1);

   // -------------------------------------------------------------
   // Conversion sequencer
   // -------------------------------------------------------------
   // The CPU clock stops in power down, so only an RC clocked
   // conversion may carry on there.
   assign abort = conv_reg != ADCC_IDLE && cpu_power_down &&
                  !ctrl_reg.rc_clock_select;
   assign finish = conv_reg == ADCC_CONVERT && !abort &&
                   cnt_reg == 8'h01 &&
                   (ctrl_reg.rc_clock_select ? rc_tick : mc_tick);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_reg <= ADCC_IDLE;
         cnt_reg <= 8'h00;
         conv_chan_reg <= `ADCC_RST_CHAN;
      end else if (clk_en) begin
         case (conv_reg)
            ADCC_IDLE: begin
               if (start_req) begin
                  conv_chan_reg <= pwdata[`ADCC_CTRL_CHAN_LSB +: 2];
                  if (pwdata[`ADCC_CTRL_RCSEL]) begin
                     conv_reg <= ADCC_SYNC;
                     cnt_reg <= 8'(SYNC_MC);
                  end else begin
                     conv_reg <= ADCC_CONVERT;
                     cnt_reg <= 8'(CONV_MC);
                  end
               end
            end
            ADCC_SYNC: begin
               if (abort) begin
                  conv_reg <= ADCC_IDLE;
               end else if (mc_tick) begin
                  if (cnt_reg == 8'h01) begin
                     conv_reg <= ADCC_CONVERT;
                     cnt_reg <= 8'(RC_TICKS);
                  end else begin
                     cnt_reg <= cnt_reg - 8'h01;
                  end
               end
            end
            ADCC_CONVERT: begin
               if (abort) begin
                  conv_reg <= ADCC_IDLE;
               end else if (finish) begin
                  conv_reg <= ADCC_IDLE;
               end else if (ctrl_reg.rc_clock_select ? rc_tick : mc_tick) begin
                  cnt_reg <= cnt_reg - 8'h01;
               end
            end
            default: begin
               conv_reg <= ADCC_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Done flag, result and validity
   // -------------------------------------------------------------
   // Completion in the same cycle as a software clear keeps the flag.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_done_flag_reg <= 1'b0;
      end else if (clk_en) begin
         if (finish) begin
            conversion_done_flag_reg <= 1'b1;
         end else if (ctrl_wr && !pwdata[`ADCC_CTRL_DONE]) begin
            conversion_done_flag_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conversion_result_reg <= `ADCC_RST_RESULT;
         result_valid_reg <= 1'b0;
         aborted_reg <= 1'b0;
      end else if (clk_en) begin
         if (finish) begin
            conversion_result_reg <= analog_code;
            result_valid_reg <= 1'b1;
         end else if (abort) begin
            result_valid_reg <= 1'b0;
            aborted_reg <= 1'b1;
         end else if (start_req) begin
            aborted_reg <= 1'b0;
         end
      end
   end

   adcc_result_mem #(
      .WIDTH(8),
      .DEPTH(4),
      .AW(2)
   ) u_hist (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .wr_en(finish),
      .wr_addr(conv_chan_reg),
      .wr_data(analog_code),
      .rd_addr(paddr[3:2]),
      .rd_data(hist_data)
   );

   // -------------------------------------------------------------
   // Interrupt, wake-up and analog controls
   // -------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_irq <= 1'b0;
         cpu_wake <= 1'b0;
         analog_channel <= `ADCC_RST_CHAN;
         analog_enable <= 1'b0;
         converting <= 1'b0;
      end else if (clk_en) begin
         // Built from next-state values so the request drops with the flag
         adc_irq <= (ctrl_wr ? pwdata[`ADCC_CTRL_IRQEN] : ctrl_reg.irq_en) &&
                    (finish || (conversion_done_flag_reg &&
                     !(ctrl_wr && !pwdata[`ADCC_CTRL_DONE])));
         // An abort never sets the flag, so it cannot wake the CPU
         cpu_wake <= finish && ctrl_reg.irq_en &&
                     (cpu_idle || cpu_power_down);
         analog_channel <= conv_reg == ADCC_IDLE ?
                           ctrl_reg.channel_select_field : conv_chan_reg;
         analog_enable <= ctrl_reg.enable;
         converting <= (conv_reg != ADCC_IDLE || start_req) &&
                       !abort && !finish;
      end
   end

endmodule

// *** logic/adcc_defines.svh ***
/*
 Timing counts, register offsets, field positions and reset values of
 the converter control block.
 Assumes inclusion by bare name from the package and the top module.
*/
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

// -------------------------------------------------------------
// Timing
// -------------------------------------------------------------
`define ADCC_CONV_MC 8'h1F
`define ADCC_SYNC_MC 8'h03
`define ADCC_RC_TICKS 8'h6C

// -------------------------------------------------------------
// Register map (byte addresses)
// -------------------------------------------------------------
`define ADCC_OFS_CTRL 12'h000
`define ADCC_OFS_RESULT 12'h004
`define ADCC_OFS_STATUS 12'h008
`define ADCC_OFS_HIST 12'h010
`define ADCC_HIST_MASK 12'hFF0

// -------------------------------------------------------------
// Control register fields
// -------------------------------------------------------------
`define ADCC_CTRL_CHAN_LSB 0
`define ADCC_CTRL_RCSEL 2
`define ADCC_CTRL_START 3
`define ADCC_CTRL_DONE 4
`define ADCC_CTRL_ENABLE 5
`define ADCC_CTRL_IRQEN 6

// -------------------------------------------------------------
// Status register fields
// -------------------------------------------------------------
`define ADCC_STAT_VALID 0
`define ADCC_STAT_ABORT 1
`define ADCC_STAT_BUSY 2

// -------------------------------------------------------------
// Reset values
// -------------------------------------------------------------
`define ADCC_RST_CHAN 2'h0
`define ADCC_RST_RESULT 8'h00

`endif

// *** logic/adcc_pkg.sv ***
/*
 Types shared by the converter control block.
 Assumes the defines header sits beside it.
*/
`include "adcc_defines.svh"

package adcc_pkg;

   // -------------------------------------------------------------
   // Control fields software writes
   // -------------------------------------------------------------
   typedef struct packed {
      logic irq_en;
      logic enable;
      logic rc_clock_select;
      logic [1:0] channel_select_field;
   } adcc_ctrl_s;

   typedef enum logic [1:0] {
      ADCC_IDLE,
      ADCC_SYNC,
      ADCC_CONVERT
   } adcc_conv_e;

   typedef enum logic [1:0] {
      ADCC_BUS_IDLE,
      ADCC_BUS_WAIT,
      ADCC_BUS_ANSWER
   } adcc_bus_e;

endpackage

// *** logic/adcc_result_mem.sv ***
/*
 Small per-channel result memory with registered read data.
 Assumes one clock, a clock enable and an active-low async reset.
*/
`timescale 1ns/1ps

module adcc_result_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4,
   parameter int AW = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem_reg [DEPTH];

   // -------------------------------------------------------------
   // Storage
   // -------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_word
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_reg[gi] <= '0;
            end else if (clk_en && wr_en && wr_addr == AW'(gi)) begin
               mem_reg[gi] <= wr_data;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else if (clk_en) begin
         rd_data <= mem_reg[rd_addr];
      end
   end

endmodule

// *** dv/adcc_asserts.sv ***
/*
 Checker for the converter control block, bound to its top module.
 Assumes one clock domain and bench stimulus that holds power down
 until a CPU clocked conversion has stopped.
*/
`timescale 1ns/1ps

module adcc_asserts
   import adcc_pkg::*;
#(
   parameter int CONV_MC = 31
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpu_power_down,
   input wire logic rc_tick,
   input wire logic [1:0] analog_channel,
   input wire logic converting,
   input wire logic adc_irq,
   input wire logic cpu_wake
);
   // -------------------------------------------------------------
   // Helper logic
   // -------------------------------------------------------------
   logic wr_ctrl;
   logic rc_mode;
   logic [1:0] chan_q;
   logic [7:0] run_cnt;
   assign wr_ctrl = psel && penable && pready && pwrite && paddr == 12'h000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_mode <= 1'h0;
         chan_q <= 2'h0;
      end else if (wr_ctrl && pwdata[3] && !converting) begin
         rc_mode <= pwdata[2];
         chan_q <= pwdata[1:0];
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_cnt <= 8'h00;
      end else begin
         run_cnt <= converting ? run_cnt + 8'h01 : 8'h00;
      end
   end
   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      !pready ##1 pready;
   endsequence
   a_bus_wait: assert property (s_setup |=> s_answer)
      else $error("bus answer not after one wait cycle");
   a_slverr_map: assert property (pready |-> pslverr == !(paddr inside
      {12'h000, 12'h004, 12'h008} || paddr[11:4] == 8'h01))
      else $error("error response mismatch");
   a_wake_pulse: assert property (cpu_wake |=> !cpu_wake)
      else $error("wake longer than one cycle");
   a_wake_cause: assert property (cpu_wake |-> adc_irq && $fell(converting))
      else $error("wake without completion");
   a_irq_sticky: assert property (adc_irq && !wr_ctrl |=> adc_irq)
      else $error("interrupt dropped without clear");
   a_irq_rise: assert property ($rose(adc_irq) && !$past(wr_ctrl)
      |-> $fell(converting)) else $error("interrupt without completion");
   a_cpu_len: assert property ($fell(converting) && !rc_mode
      && !$past(cpu_power_down) |-> run_cnt == CONV_MC)
      else $error("conversion length wrong");
   a_rc_end: assert property ($fell(converting) && rc_mode
      |-> $past(rc_tick)) else $error("RC conversion ended off a tick");
   a_pd_abort: assert property (converting && cpu_power_down && !rc_mode
      |-> ##[1:2] !converting) else $error("no abort in power down");
   a_chan_hold: assert property (converting |-> analog_channel == chan_q)
      else $error("channel not held while converting");
endmodule

bind adcc_top adcc_asserts #(.CONV_MC(CONV_MC)) u_asserts (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .cpu_power_down(cpu_power_down), .rc_tick(rc_tick),
   .analog_channel(analog_channel), .converting(converting),
   .adc_irq(adc_irq), .cpu_wake(cpu_wake));

// *** dv/adcc_analog_model.sv ***
/*
 Model of the analog core and RC oscillator beside the block.
 Assumes the RC tick is divided down from pclk, far slower in reality.
*/
`timescale 1ns/1ps

module adcc_analog_model
   import adcc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] analog_channel,
   input wire logic analog_enable,
   input wire logic [7:0] code_base,
   output logic rc_tick,
   output logic [7:0] analog_code
);
   logic [1:0] div_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 2'h0;
         rc_tick <= 1'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
         rc_tick <= div_reg == 2'h3;
      end
   end
   // A disabled core gives junk, so a missing enable shows up
   assign analog_code = analog_enable ? code_base + {6'h00, analog_channel}
                                      : ~code_base;
endmodule

// *** dv/adcc_tb_top.sv ***
/*
 Self-checking bench for the converter control block.
 Assumes the analog model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`include "adcc_defines.svh"
`define CHK(nm, e, g) \
   begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end

module adcc_tb_top
   import adcc_pkg::*;
;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic cpu_idle = 1'h0;
   logic cpu_power_down = 1'h0;
   logic [7:0] base = 8'h00;
   logic [31:0] prdata, rd;
   logic pready, pslverr, slv, rc_tick, analog_enable, converting;
   logic adc_irq, cpu_wake;
   logic [7:0] analog_code;
   logic [1:0] analog_channel;
   int errors = 0;
   int n_compared = 0;

   always #12.5 pclk = ~pclk;

   adcc_top #(.CONV_MC(4), .RC_TICKS(4)) DUT (
      .pclk(pclk), .presetn(presetn), .clk_en(1'h1), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cpu_idle(cpu_idle), .cpu_power_down(cpu_power_down),
      .rc_tick(rc_tick), .analog_code(analog_code),
      .analog_channel(analog_channel), .analog_enable(analog_enable),
      .converting(converting), .adc_irq(adc_irq), .cpu_wake(cpu_wake));

   adcc_analog_model u_analog (
      .pclk(pclk), .presetn(presetn), .analog_channel(analog_channel),
      .analog_enable(analog_enable), .code_base(base), .rc_tick(rc_tick),
      .analog_code(analog_code));

   function automatic logic [31:0] cw(input logic [1:0] ch,
                                      input logic rc, st, ie);
      cw = {25'h0, ie, 1'h1, 1'h0, st, rc, ch};
   endfunction

   // -------------------------------------------------------------
   // Bus master: held until pready is sampled high
   // -------------------------------------------------------------
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      // No wait limit here: only the watchdog ends a hung transfer
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      q = prdata;
      slv = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   // -------------------------------------------------------------
   // One conversion; mode 0 polled, 1 idle, 2 power down
   // -------------------------------------------------------------
   task automatic conv(input logic [1:0] ch, input logic rc, ie,
                       input int mode);
      logic woke;
      logic ab;
      ab = mode == 2 && !rc;
      base <= 8'($urandom);
      apb(1'h1, `ADCC_OFS_CTRL, cw(ch, rc, 1'h0, ie), rd);
      apb(1'h1, `ADCC_OFS_CTRL, cw(ch, rc, 1'h1, ie), rd);
      // Bench has no other wake source, so only completion can wake
      cpu_idle <= mode == 1;
      cpu_power_down <= mode == 2;
      woke = 1'h0;
      do begin
         @(posedge pclk);
         woke |= cpu_wake === 1'h1;
      end while (converting === 1'h1);
      cpu_idle <= 1'h0;
      cpu_power_down <= 1'h0;
      `CHK("wake", ie && mode != 0 && !ab, woke);
      `CHK("irq", ie && !ab, adc_irq);
      apb(1'h0, `ADCC_OFS_STATUS, 32'h0, rd);
      `CHK("status", ab ? 32'h2 : 32'h1, rd);
      apb(1'h0, `ADCC_OFS_CTRL, 32'h0, rd);
      `CHK("done", !ab, rd[4]);
      if (!ab) begin
         apb(1'h0, `ADCC_OFS_RESULT, 32'h0, rd);
         `CHK("result", {24'h0, base + 8'(ch)}, rd);
         apb(1'h0, 12'h010 + {8'h0, ch, 2'h0}, 32'h0, rd);
         `CHK("history", {24'h0, base + 8'(ch)}, rd);
         apb(1'h1, `ADCC_OFS_CTRL, cw(ch, rc, 1'h1, ie) | 32'h10, rd);
         `CHK("blocked", 1'h0, converting);
         apb(1'h0, `ADCC_OFS_CTRL, 32'h0, rd);
         apb(1'h1, `ADCC_OFS_CTRL, rd & 32'hEC, rd);
         `CHK("irq clear", 1'h0, adc_irq);
      end
      $display("test conversion mode %0d rc %0d done", mode, rc);
   endtask

   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // Sequence
   // -------------------------------------------------------------
   initial begin
      void'($urandom(32'h11D6C7EF));
      repeat (10) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, `ADCC_OFS_CTRL, 32'h0, rd);
      `CHK("ctrl reset", 32'h0, rd);
      apb(1'h1, `ADCC_OFS_RESULT, 32'hFF, rd);
      apb(1'h0, `ADCC_OFS_RESULT, 32'h0, rd);
      `CHK("result reset", 32'h0, rd);
      apb(1'h0, 12'h020, 32'h0, rd);
      `CHK("unmapped err", 1'h1, slv);
      `CHK("unmapped data", 32'h0, rd);
      $display("test registers done");
      for (int i = 0; i < 8; i++) begin
         conv(2'($urandom), 1'h0, 1'($urandom), 0);
      end
      conv(2'h3, 1'h0, 1'h1, 1);
      conv(2'h1, 1'h0, 1'h1, 2);
      // Bench CPU clock stands for a slow part, so RC select is allowed
      conv(2'h2, 1'h1, 1'h1, 2);
      conv(2'h0, 1'h1, 1'h0, 0);
      end_of_test();
   end

   initial begin
      // Run needs several hundred cycles; the margin is generous
      repeat (20000) @(posedge pclk);
      errors++;
      end_of_test();
   end
endmodule
